// ===== src/cbl_pkg.sv
// Contract
// [RULE1] full load after every power-up before operating
// [RULE2] restart pin low starts a fresh load
// [RULE3] master serial: device makes clock, bit per clock
// [RULE4] slave serial: source supplies clock with data
// [RULE5] byte port 8/16 bit, master drives clock
// [RULE6] stream option may switch to external clock
// [RULE7] accept serial data over boundary-scan port
// [RULE8] trigger by power-on reset or restart pin
// [RULE9] erase whole configuration memory before loading
// [RULE10] sample mode pins after clearing
// [RULE11] width pattern then sync word set alignment
// [RULE12] accept only stream with matching device code
// [RULE13] end with CRC over whole stream; the code's CRC skips the sync word and width pattern
// [RULE14] start-up releases reset on user flip-flops
// [RULE15] optionally wait for clock lock in start-up
// [RULE16] enable outputs, then drive complete high
// [RULE17] serial-flash master: read SPI flash
// [RULE18] parallel-flash master: drive NOR address, read
// [RULE19] user logic picks next image and time
// [RULE20] readable factory unique die identifier
// [RULE21] decrypt encrypted bitstreams while loading
// [RULE22] readback without disturbing running design
// [RULE23] bad code or CRC: abort, complete stays low
// [RULE24] mode pins sampled once per attempt
package cbl_pkg;
	localparam int          CFG_WORDS     = 256;
	localparam int          CFG_AW        = 8;
	localparam logic [7:0]  CFG_LAST      = 8'hff;
	localparam logic [31:0] SYNC_WORD     = 32'h5a3cc3a5;
	localparam logic [7:0]  BW_DET_FIRST  = 8'hbb;
	localparam logic [7:0]  BW_DET_SECOND = 8'h11;
	localparam logic [7:0]  SPI_READ_CMD  = 8'h03;
	localparam logic [2:0]  CFG_SHIFT_CLOCK_HALF     = 3'h4;
	localparam logic [31:0] CRC_INIT      = 32'hffffffff;
	localparam logic [31:0] CRC_POLY      = 32'h04c11db7;
	localparam int          OPT_EXT_CLK   = 0;
	localparam int          OPT_WAIT_LOCK = 1;
	localparam int          OPT_ENCRYPT   = 2;
	localparam int          OPT_LEN_LSB   = 16;
	localparam int          LEN_W         = 16;
	localparam int          DIE_ID_W      = 57;
	localparam logic [1:0]  SU_RELEASE    = 2'h0;
	localparam logic [1:0]  SU_LOCK       = 2'h1;
	localparam logic [1:0]  SU_OUTEN      = 2'h2;
	localparam logic [1:0]  SU_DONE       = 2'h3;

	typedef enum logic [2:0] {
		MODE_SPI   = 3'h0,
		MODE_BPI   = 3'h1,
		MODE_SSER  = 3'h2,
		MODE_SBYTE = 3'h3,
		MODE_JTAG  = 3'h4
	} cbl_mode_e;

	typedef enum logic [9:0] {
		ST_CLEAR   = 10'h001,
		ST_SAMPLE  = 10'h002,
		ST_SYNC    = 10'h004,
		ST_DEVCODE = 10'h008,
		ST_OPTS    = 10'h010,
		ST_LOAD    = 10'h020,
		ST_CHECK   = 10'h040,
		ST_START   = 10'h080,
		ST_DONE    = 10'h100,
		ST_ERROR   = 10'h200
	} cbl_state_e;
endpackage

// ===== src/cbl_link_if.sv
`timescale 1ns/10ps
interface cbl_link_if;
	logic        arm;
	logic        byte_port;
	logic        jtag_sel;
	logic [31:0] word;
	logic        word_tgl;

	modport ctl (output arm, output byte_port, output jtag_sel, input word, input word_tgl);
	modport rx  (input arm, input byte_port, input jtag_sel, output word, output word_tgl);
endinterface

// ===== src/cbl_crc.sv
`timescale 1ns/10ps
module cbl_crc
	import cbl_pkg::*;
(
	input  wire logic [31:0] crc_in,
	input  wire logic [31:0] data,
	output logic      [31:0] crc_out
);
	always_comb begin
		logic [31:0] c;
		c = crc_in;
		for (int i = 31; i >= 0; i--) begin
			if (c[31] ^ data[i])
				c = {c[30:0], 1'b0} ^ CRC_POLY;
			else
				c = {c[30:0], 1'b0};
		end
		crc_out = c;
	end
endmodule // cbl_crc

// ===== src/cbl_link_rx.sv
`timescale 1ns/10ps
module cbl_link_rx
	import cbl_pkg::*;
(
	input  wire logic        link_clk,
	input  wire logic [15:0] cfg_data,
	input  wire logic        ser_din,
	input  wire logic        jtag_din,
	cbl_link_if.rx           lnk
);
	// link clock may stop between loads, so state is cleared by the armed level, not a reset
	logic        arm_s1_r, arm_s2_r;
	logic        wknown_r, x16_r, half_r, aligned_r, tgl_r;
	logic [5:0]  cnt_r;
	logic [31:0] sh_r, word_r;
	logic [31:0] sh_nxt;
	logic [5:0]  step, cnt_nxt;

	always_ff @(posedge link_clk) begin
		arm_s1_r <= lnk.arm;
		arm_s2_r <= arm_s1_r;
	end

	always_comb begin
		if (!lnk.byte_port) begin
			step   = 6'h01;
			sh_nxt = {sh_r[30:0], lnk.jtag_sel ? jtag_din : ser_din}; // RULE7 RULE3 RULE4
		end else if (x16_r) begin
			step   = 6'h10;
			sh_nxt = {sh_r[15:0], cfg_data};
		end else begin
			step   = 6'h08;
			sh_nxt = {sh_r[23:0], cfg_data[7:0]};
		end
		cnt_nxt = cnt_r + step;
	end

	always_ff @(posedge link_clk) begin
		if (!arm_s2_r) begin
			wknown_r <= 1'b0;
			x16_r    <= 1'b0;
			half_r   <= 1'b0;
		end else if (!lnk.byte_port) begin
			wknown_r <= 1'b1;
		end else if (!wknown_r) begin
			half_r <= (cfg_data[7:0] == BW_DET_FIRST);
			if (cfg_data[7:0] == BW_DET_FIRST && cfg_data[15:8] == BW_DET_SECOND) begin // RULE11 RULE5
				wknown_r <= 1'b1;
				x16_r    <= 1'b1;
			end else if (half_r && cfg_data[7:0] == BW_DET_SECOND) begin
				wknown_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge link_clk) begin
		if (!arm_s2_r) begin
			sh_r      <= 32'h0;
			aligned_r <= 1'b0;
			cnt_r     <= 6'h0;
		end else if (wknown_r) begin
			sh_r <= sh_nxt;
			if (!aligned_r) begin
				if (sh_nxt == SYNC_WORD) // RULE11
					aligned_r <= 1'b1;
			end else begin
				cnt_r <= (cnt_nxt == 6'h20) ? 6'h0 : cnt_nxt;
			end
		end
	end

	// word is held until the next one completes, the toggle tells the system side
	always_ff @(posedge link_clk) begin
		if (!arm_s2_r) begin
			tgl_r <= 1'b0;
		end else if (wknown_r && aligned_r && cnt_nxt == 6'h20) begin
			word_r <= sh_nxt;
			tgl_r  <= ~tgl_r;
		end
	end

	assign lnk.word     = word_r;
	assign lnk.word_tgl = tgl_r;
endmodule // cbl_link_rx

// ===== src/cbl_loader.sv
`timescale 1ns/10ps
module cbl_loader
	import cbl_pkg::*;
#(
	parameter logic [31:0]         DEVICE_CODE = 32'h00c0ffee, // arbitrary value
	parameter logic [DIE_ID_W-1:0] DIE_ID      = 57'h0123456789abcde, // arbitrary value
	parameter logic [31:0]         DECRYPT_KEY = 32'h1f2e3d4c
)(
	input  wire logic                mclk,
	input  wire logic                sys_rst,
	input  wire logic                cfg_shift_clock_i,
	output logic                     cfg_shift_clock_o,
	output logic                     cfg_shift_clock_oe,
	input  wire logic                prog_n,
	input  wire logic [2:0]          mode_pins,
	input  wire logic [15:0]         cfg_data,
	input  wire logic                ser_din,
	input  wire logic                jtag_tdi,
	output logic                     spi_cs_n,
	output logic                     spi_mosi,
	output logic [23:0]              flash_addr,
	output logic                     flash_ce_n,
	output logic                     flash_oe_n,
	input  wire logic                pll_locked,
	input  wire logic                reboot_req,
	input  wire logic [23:0]         next_image_addr,
	input  wire logic                rb_req,
	input  wire logic [CFG_AW-1:0]   rb_addr,
	output logic [31:0]              rb_data,
	output logic                     rb_valid,
	output logic [DIE_ID_W-1:0]      die_id,
	output logic                     user_rst,
	output logic                     io_out_en,
	output logic                     done,
	output logic                     cfg_error,
	output logic                     cfg_busy
);
	import cbl_pkg::*;

	cbl_link_if lnk ();

	cbl_state_e       state_r;
	cbl_mode_e        mode_r;
	logic [4:0]       pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r;
	logic             tg_s1_r, tg_s2_r, tg_s3_r, tg_seen_r;
	logic             word_stb, prog_low, lock_f, restart;
	logic [31:0]      word_in, plain, crc_r, crc_nxt, key_r, spi_sh_r;
	logic [31:0]      opts_r;
	logic [LEN_W-1:0] len_r;
	logic [CFG_AW-1:0] clr_idx_r, wr_idx_r;
	logic [1:0]       su_step_r;
	logic [23:0]      start_addr_r, flash_addr_r;
	logic [2:0]       div_r;
	logic             cfg_shift_clock_r, cfg_shift_clock_fall;
	logic             loading, master, rb_valid_r, user_rst_r, io_out_en_r, done_r;
	logic [5:0]       spi_bits_r;
	logic [31:0]      rb_data_r;
	logic [DIE_ID_W-1:0] die_id_r;
	logic [31:0]      cfg_mem [CFG_WORDS];

	// outside pins: three stages, a new value is taken once stages two and three agree
	always_ff @(posedge mclk) begin
		pin_s1_r <= {mode_pins, pll_locked, prog_n};
		pin_s2_r <= pin_s1_r;
		pin_s3_r <= pin_s2_r;
		if (sys_rst)
			pin_f_r <= 5'h01;
		else if (pin_s2_r == pin_s3_r)
			pin_f_r <= pin_s3_r;
	end
	assign prog_low = ~pin_f_r[0];
	assign lock_f   = pin_f_r[1];
	assign restart  = prog_low | reboot_req; // RULE2 RULE19

	// word toggle from the link domain
	always_ff @(posedge mclk) begin
		tg_s1_r <= lnk.word_tgl;
		tg_s2_r <= tg_s1_r;
		tg_s3_r <= tg_s2_r;
		if (sys_rst)
			tg_seen_r <= 1'b0;
		else if (tg_s2_r == tg_s3_r)
			tg_seen_r <= tg_s3_r;
	end
	assign word_stb = (tg_s2_r == tg_s3_r) && (tg_s3_r != tg_seen_r);
	// the link holds the word for a full word time, long enough to read it here directly
	assign word_in  = lnk.word;

	// plain keystream stage: stands where a block cipher core would sit
	assign plain = opts_r[OPT_ENCRYPT] ? (word_in ^ key_r) : word_in; // RULE21

	cbl_crc u_crc (
		.crc_in  (crc_r),
		.data    (word_in),
		.crc_out (crc_nxt)
	);

	assign loading = (state_r == ST_SYNC) || (state_r == ST_DEVCODE) || (state_r == ST_OPTS) ||
	                 (state_r == ST_LOAD) || (state_r == ST_CHECK);
	assign master  = (mode_r == MODE_SPI) || (mode_r == MODE_BPI);

	assign lnk.arm       = loading;
	assign lnk.byte_port = (mode_r == MODE_BPI) || (mode_r == MODE_SBYTE);
	assign lnk.jtag_sel  = (mode_r == MODE_JTAG);

	cbl_link_rx u_rx (
		.link_clk (cfg_shift_clock_i),
		.cfg_data (cfg_data),
		.ser_din  (ser_din),
		.jtag_din (jtag_tdi),
		.lnk      (lnk)
	);

	// sequence: power-on reset lands in clear, a restart always goes back there
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_r <= ST_CLEAR; // RULE8 RULE1
		end else if (restart) begin
			state_r <= ST_CLEAR; // RULE2 RULE8
		end else begin
			case (state_r)
				ST_CLEAR:   if (clr_idx_r == CFG_LAST) state_r <= ST_SAMPLE; // RULE9
				ST_SAMPLE:  state_r <= ST_SYNC; // RULE10
				ST_SYNC:    if (word_stb) state_r <= (word_in == DEVICE_CODE) ? ST_OPTS : ST_ERROR; // RULE12 RULE23
				ST_DEVCODE: state_r <= ST_SYNC;
				ST_OPTS:    if (word_stb) state_r <= (word_in[OPT_LEN_LSB +: LEN_W] == '0) ? ST_CHECK : ST_LOAD;
				ST_LOAD:    if (word_stb && len_r == 16'h0001) state_r <= ST_CHECK;
				ST_CHECK:   if (word_stb) state_r <= (word_in == crc_r) ? ST_START : ST_ERROR; // RULE13 RULE23
				ST_START:   if (su_step_r == SU_DONE) state_r <= ST_DONE;
				ST_DONE:    state_r <= ST_DONE;
				ST_ERROR:   state_r <= ST_ERROR; // RULE23
				default:    state_r <= ST_CLEAR;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || state_r != ST_CLEAR)
			clr_idx_r <= '0;
		else
			clr_idx_r <= clr_idx_r + 8'h01;
	end

	// mode pins are caught once per attempt
	always_ff @(posedge mclk) begin
		if (sys_rst)
			mode_r <= MODE_SPI;
		else if (state_r == ST_SAMPLE)
			mode_r <= cbl_mode_e'(pin_f_r[4:2]); // RULE10 RULE24
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || state_r == ST_CLEAR) begin
			opts_r <= 32'h0;
			len_r  <= '0;
			crc_r  <= CRC_INIT;
			key_r  <= DECRYPT_KEY;
		end else if (word_stb) begin
			if (state_r == ST_SYNC || state_r == ST_OPTS || state_r == ST_LOAD)
				crc_r <= crc_nxt; // RULE13
			if (state_r == ST_OPTS) begin
				opts_r <= word_in; // RULE6
				len_r  <= word_in[OPT_LEN_LSB +: LEN_W];
			end
			if (state_r == ST_LOAD) begin
				len_r <= len_r - 16'h0001;
				if (opts_r[OPT_ENCRYPT])
					key_r <= {key_r[30:0], key_r[31]} ^ word_in; // RULE21
			end
		end
	end

	// one port erases and loads, the other serves readback only
	always_ff @(posedge mclk) begin
		if (state_r == ST_CLEAR)
			cfg_mem[clr_idx_r] <= 32'h0; // RULE9
		else if (state_r == ST_LOAD && word_stb)
			cfg_mem[wr_idx_r] <= plain;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || state_r == ST_CLEAR)
			wr_idx_r <= '0;
		else if (state_r == ST_LOAD && word_stb && wr_idx_r != CFG_LAST)
			wr_idx_r <= wr_idx_r + 8'h01;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rb_valid_r <= 1'b0;
			rb_data_r  <= 32'h0;
		end else begin
			rb_valid_r <= rb_req;
			if (rb_req)
				rb_data_r <= cfg_mem[rb_addr]; // RULE22
		end
	end

	// start-up: release user reset, optional lock wait, drivers on, then complete
	always_ff @(posedge mclk) begin
		if (sys_rst || state_r != ST_START)
			su_step_r <= SU_RELEASE;
		else if (su_step_r == SU_RELEASE)
			su_step_r <= SU_LOCK;
		else if (su_step_r == SU_LOCK && (lock_f || !opts_r[OPT_WAIT_LOCK]))
			su_step_r <= SU_OUTEN; // RULE15
		else if (su_step_r == SU_OUTEN)
			su_step_r <= SU_DONE;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || restart || state_r == ST_CLEAR || state_r == ST_ERROR) begin
			user_rst_r  <= 1'b1;
			io_out_en_r <= 1'b0;
			done_r      <= 1'b0; // RULE1 RULE23
		end else if (state_r == ST_START) begin
			user_rst_r <= 1'b0; // RULE14
			if (su_step_r == SU_OUTEN)
				io_out_en_r <= 1'b1; // RULE16
			if (su_step_r == SU_DONE)
				done_r <= 1'b1; // RULE16
		end
	end

	// shift clock for master modes, a divider of mclk; pin is released for an external clock
	always_ff @(posedge mclk) begin
		if (sys_rst || !loading || !master || opts_r[OPT_EXT_CLK]) begin
			div_r  <= 3'h0;
			cfg_shift_clock_r <= 1'b0;
		end else if (div_r == CFG_SHIFT_CLOCK_HALF - 3'h1) begin
			div_r  <= 3'h0;
			cfg_shift_clock_r <= ~cfg_shift_clock_r; // RULE3 RULE5
		end else begin
			div_r <= div_r + 3'h1;
		end
	end
	assign cfg_shift_clock_fall = cfg_shift_clock_r && (div_r == CFG_SHIFT_CLOCK_HALF - 3'h1);

	always_ff @(posedge mclk) begin
		if (sys_rst)
			start_addr_r <= 24'h0;
		else if (reboot_req)
			start_addr_r <= next_image_addr; // RULE19
	end

	// read command and address go out on falling edges, the flash answers for rising ones
	always_ff @(posedge mclk) begin
		if (sys_rst || state_r == ST_SAMPLE) begin
			spi_sh_r   <= {SPI_READ_CMD, start_addr_r}; // RULE17
			spi_bits_r <= 6'h0;
		end else if (cfg_shift_clock_fall && spi_bits_r != 6'h20) begin
			spi_sh_r   <= {spi_sh_r[30:0], 1'b0};
			spi_bits_r <= spi_bits_r + 6'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || state_r == ST_SAMPLE)
			flash_addr_r <= start_addr_r;
		else if (cfg_shift_clock_fall && mode_r == MODE_BPI)
			flash_addr_r <= flash_addr_r + 24'h000001; // RULE18
	end

	always_ff @(posedge mclk) begin
		if (sys_rst)
			die_id_r <= DIE_ID;
		else
			die_id_r <= DIE_ID; // RULE20
	end

	assign cfg_shift_clock_o  = cfg_shift_clock_r;
	assign cfg_shift_clock_oe = loading && master && !opts_r[OPT_EXT_CLK]; // RULE6
	assign spi_cs_n           = !(loading && mode_r == MODE_SPI); // RULE17
	assign spi_mosi           = spi_sh_r[31];
	assign flash_addr         = flash_addr_r;
	assign flash_ce_n         = !(loading && mode_r == MODE_BPI); // RULE18
	assign flash_oe_n         = !(loading && mode_r == MODE_BPI);
	assign rb_data            = rb_data_r;
	assign rb_valid           = rb_valid_r;
	assign die_id             = die_id_r;
	assign user_rst           = user_rst_r;
	assign io_out_en          = io_out_en_r;
	assign done               = done_r;
	assign cfg_error          = (state_r == ST_ERROR);
	assign cfg_busy           = loading || state_r == ST_CLEAR || state_r == ST_SAMPLE || state_r == ST_START;

	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	prog_restart_a: assert property (prog_low |=> state_r == ST_CLEAR) // RULE2
		else $error("restart pin did not return to clear");
	clear_first_a: assert property ($rose(state_r == ST_SAMPLE) |-> $past(clr_idx_r) == CFG_LAST) // RULE9
		else $error("left clear before whole memory erased");
	mode_once_a: assert property (state_r != ST_SAMPLE |=> $stable(mode_r)) // RULE24
		else $error("mode changed outside sampling");
	code_reject_a: assert property (state_r == ST_SYNC && word_stb && word_in != DEVICE_CODE && !restart
		|=> state_r == ST_ERROR) // RULE12
		else $error("wrong device code accepted");
	crc_check_a: assert property (state_r == ST_CHECK && word_stb && !restart
		|=> state_r == (word_in == crc_r ? ST_START : ST_ERROR)) // RULE13
		else $error("crc outcome wrong");
	error_low_a: assert property (state_r == ST_ERROR |-> !done && user_rst && !io_out_en) // RULE23
		else $error("complete raised after failed load");
	done_order_a: assert property ($rose(done) |-> io_out_en && $past(io_out_en) && !user_rst) // RULE16
		else $error("complete before outputs enabled");
	lock_wait_a: assert property (state_r == ST_START && su_step_r == SU_LOCK && opts_r[OPT_WAIT_LOCK] && !lock_f
		|=> !io_out_en [*2]) // RULE15
		else $error("start-up did not wait for lock");
	master_clk_a: assert property (cfg_shift_clock_oe |-> master && loading) // RULE3
		else $error("shift clock driven outside master load");
	readback_a: assert property (rb_req && !(state_r == ST_LOAD && word_stb) && state_r != ST_CLEAR
		|=> rb_valid && rb_data == cfg_mem[$past(rb_addr)]) // RULE22
		else $error("readback data mismatch");
endmodule // cbl_loader

// ===== tb/cbl_host_model.sv
`timescale 1ns/10ps
module cbl_host_model (
	input  wire logic   shift_o,
	input  wire logic   shift_oe,
	output logic        link_pin,
	output logic [15:0] cfg_data,
	output logic        ser_din,
	output logic        jtag_tdi
);
	logic clk_r = 1'b0;

	// master modes loop the device's own clock back onto the pin
	assign link_pin = shift_oe ? shift_o : clk_r;

	initial begin
		cfg_data = 16'h0000;
		ser_din = 1'b0;
		jtag_tdi = 1'b0;
	end

	// one link cycle; the clock stands low outside these calls
	task automatic edge_out(input logic [15:0] d, input logic b);
		cfg_data = d;
		ser_din = b;
		jtag_tdi = b;
		#7.5 clk_r = 1'b1;
		#7.5 clk_r = 1'b0;
	endtask

	task automatic send_word(input logic [31:0] w, input logic wide);
		if (wide) begin
			edge_out(w[31:16], 1'b0);
			edge_out(w[15:0], 1'b0);
			// x16 outruns the receiver, so the clock stops between words
			#30;
		end else begin
			for (int i = 31; i >= 0; i--)
				edge_out(16'h0000, w[i]);
		end
	endtask

	// released lines must not keep showing the last value
	task automatic release_lines();
		cfg_data = ~cfg_data;
		ser_din = ~ser_din;
		jtag_tdi = ~jtag_tdi;
	endtask
endmodule // cbl_host_model

// ===== tb/configuration_bitstream_loader_tb_top.sv
`timescale 1ns/10ps
module configuration_bitstream_loader_tb_top;
	import cbl_pkg::*;
	localparam logic [31:0]         DEV_CODE = 32'h00a1b2c3; // arbitrary value
	localparam logic [DIE_ID_W-1:0] DIE_VAL  = 57'h055aa33cc0ff00; // arbitrary value
	localparam logic [31:0]         PAY0     = 32'hc0de5a01;
	localparam logic [31:0]         KEY0     = 32'h6b1d0e73;

	typedef struct packed {
		logic [2:0]  mode;
		logic [31:0] code;
		logic        bad_crc;
		logic        ok;
		logic [31:0] rb0;
	} cbl_row_s;

	logic                mclk = 1'b0;
	logic                sys_rst = 1'b1;
	logic                prog_n = 1'b1;
	logic [2:0]          mode_pins = 3'h2;
	logic                pll_locked = 1'b1;
	logic                reboot_req = 1'b0;
	logic [23:0]         next_image_addr = 24'h000000;
	logic                rb_req = 1'b0;
	logic [7:0]          rb_addr = 8'h00;
	logic                link_pin, shift_o, shift_oe, ser_din, jtag_tdi;
	logic                spi_cs_n, spi_mosi, flash_ce_n, flash_oe_n;
	logic [15:0]         cfg_data;
	logic [23:0]         flash_addr;
	logic [31:0]         rb_data;
	logic                rb_valid, user_rst, io_out_en, done, cfg_error, cfg_busy;
	logic [DIE_ID_W-1:0] die_id;
	logic [7:0]          cmd;
	cbl_row_s            rows [5];
	int                  err_count = 0;
	int                  checks_done = 0;
	int                  cyc = 0;

	cbl_loader #(.DEVICE_CODE(DEV_CODE), .DIE_ID(DIE_VAL), .DECRYPT_KEY(KEY0)) cbl_loader_i (
		.mclk(mclk), .sys_rst(sys_rst), .cfg_shift_clock_i(link_pin), .cfg_shift_clock_o(shift_o),
		.cfg_shift_clock_oe(shift_oe), .prog_n(prog_n), .mode_pins(mode_pins), .cfg_data(cfg_data),
		.ser_din(ser_din), .jtag_tdi(jtag_tdi), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
		.flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
		.pll_locked(pll_locked), .reboot_req(reboot_req), .next_image_addr(next_image_addr),
		.rb_req(rb_req), .rb_addr(rb_addr), .rb_data(rb_data), .rb_valid(rb_valid), .die_id(die_id),
		.user_rst(user_rst), .io_out_en(io_out_en), .done(done), .cfg_error(cfg_error),
		.cfg_busy(cfg_busy)
	);

	cbl_host_model cbl_host_model_i (
		.shift_o(shift_o), .shift_oe(shift_oe), .link_pin(link_pin), .cfg_data(cfg_data),
		.ser_din(ser_din), .jtag_tdi(jtag_tdi)
	);

	initial begin
		forever #4 mclk = ~mclk;
	end

	task automatic chk_bit(input string n, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %b seen %b", n, e, g);
		end
	endtask

	task automatic chk_val(input string n, input logic [63:0] e, input logic [63:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			$display("[FAIL] run_length expected finish seen hang");
			end_of_test();
		end
	end

	task automatic cycles(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// msb first, no reflection, kept apart from the design's own code
	function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 31; i >= 0; i--)
			r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? CRC_POLY : 32'h00000000);
		return r;
	endfunction

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		rb_req <= 1'b1;
		rb_addr <= a;
		@(posedge mclk);
		rb_req <= 1'b0;
		#1;
		if (rb_valid !== 1'b1) begin
			@(posedge mclk);
			#1;
		end
		chk_bit("rb_valid", 1'b1, rb_valid);
		chk_val("rb_data", {32'h0, e}, {32'h0, rb_data});
	endtask

	task automatic restart(input logic [2:0] m);
		@(posedge mclk);
		mode_pins <= m;
		prog_n <= 1'b0;
		cycles(6);
		prog_n <= 1'b1;
	endtask

	task automatic load(input logic [2:0] m, input logic [31:0] code, input logic [31:0] opt,
			input logic bad_crc);
		logic [31:0] c;
		logic        wide;
		wide = (m == 3'h3);
		c = crc_word(crc_word(crc_word(crc_word(CRC_INIT, code), opt), PAY0), ~PAY0);
		restart(m);
		// link side only sees the disarm on its own edges, and its clock stops between loads
		repeat (4) cbl_host_model_i.edge_out(16'h0000, 1'b0);
		cycles(300);
		// a resample here would turn the slave load into a flash read
		mode_pins <= 3'h0;
		repeat (8) cbl_host_model_i.edge_out(16'h0000, 1'b0);
		if (wide)
			cbl_host_model_i.edge_out(16'h11bb, 1'b0);
		cbl_host_model_i.send_word(SYNC_WORD, wide);
		cbl_host_model_i.send_word(code, wide);
		cbl_host_model_i.send_word(opt, wide);
		cbl_host_model_i.send_word(PAY0, wide);
		cbl_host_model_i.send_word(~PAY0, wide);
		cbl_host_model_i.send_word(c ^ {31'h0, bad_crc}, wide);
		cbl_host_model_i.release_lines();
		@(posedge mclk);
		#1;
		chk_bit("shift_clock_oe_slave", 1'b0, shift_oe);
		chk_bit("spi_cs_n_slave", 1'b1, spi_cs_n);
	endtask

	task automatic wait_end();
		for (int k = 0; k < 300 && done !== 1'b1 && cfg_error !== 1'b1; k++)
			@(posedge mclk);
		cycles(2);
		#1;
	endtask

	initial begin
		rows[0] = '{3'h2, DEV_CODE, 1'b0, 1'b1, PAY0};
		rows[1] = '{3'h4, DEV_CODE, 1'b0, 1'b1, PAY0};
		rows[2] = '{3'h3, DEV_CODE, 1'b0, 1'b1, PAY0};
		rows[3] = '{3'h2, ~DEV_CODE, 1'b0, 1'b0, 32'h00000000};
		rows[4] = '{3'h2, DEV_CODE, 1'b1, 1'b0, PAY0};
		cycles(20);
		sys_rst <= 1'b0;
		cycles(2);
		#1;
		chk_bit("busy_after_reset", 1'b1, cfg_busy);
		chk_val("die_id", {7'h0, DIE_VAL}, {7'h0, die_id});
		cycles(400);
		#1;
		chk_bit("done_unloaded", 1'b0, done);
		chk_bit("user_rst_unloaded", 1'b1, user_rst);
		$display("reset test done");
		for (int r = 0; r < 5; r++) begin
			load(rows[r].mode, rows[r].code, 32'h00020000, rows[r].bad_crc);
			wait_end();
			chk_bit("done", rows[r].ok, done);
			chk_bit("cfg_error", ~rows[r].ok, cfg_error);
			chk_bit("user_rst", ~rows[r].ok, user_rst);
			chk_bit("io_out_en", rows[r].ok, io_out_en);
			rd(8'h00, rows[r].rb0);
			$display("row %0d test done", r);
		end
		@(posedge mclk);
		pll_locked <= 1'b0;
		load(3'h2, DEV_CODE, 32'h00020002, 1'b0);
		cycles(200);
		#1;
		chk_bit("done_wait_lock", 1'b0, done);
		chk_bit("user_rst_wait_lock", 1'b0, user_rst);
		@(posedge mclk);
		pll_locked <= 1'b1;
		wait_end();
		chk_bit("done_after_lock", 1'b1, done);
		chk_bit("io_out_en_after_lock", 1'b1, io_out_en);
		$display("lock test done");
		load(3'h2, DEV_CODE, 32'h00020004, 1'b0);
		wait_end();
		chk_bit("done_encrypted", 1'b1, done);
		rd(8'h00, PAY0 ^ KEY0);
		$display("encrypt test done");
		restart(3'h0);
		for (int k = 0; k < 400 && spi_cs_n !== 1'b0; k++)
			@(posedge mclk);
		#1;
		chk_bit("spi_cs_n_master", 1'b0, spi_cs_n);
		chk_bit("shift_clock_oe_master", 1'b1, shift_oe);
		cmd = 8'h00;
		repeat (8) begin
			@(posedge link_pin);
			cmd = {cmd[6:0], spi_mosi};
		end
		chk_val("spi_read_cmd", {56'h0, SPI_READ_CMD}, {56'h0, cmd});
		$display("serial flash test done");
		@(posedge mclk);
		next_image_addr <= 24'h3c0a50;
		mode_pins <= 3'h1;
		reboot_req <= 1'b1;
		@(posedge mclk);
		reboot_req <= 1'b0;
		for (int k = 0; k < 400 && flash_ce_n !== 1'b0; k++)
			@(posedge mclk);
		#1;
		chk_val("flash_start", {40'h0, 24'h3c0a50}, {40'h0, flash_addr});
		chk_bit("flash_oe_n", 1'b0, flash_oe_n);
		cycles(32);
		#1;
		chk_bit("flash_addr_moves", 1'b1, flash_addr > 24'h3c0a50);
		$display("parallel flash test done");
		end_of_test();
	end
endmodule // configuration_bitstream_loader_tb_top
